// ===== psm_pkg.sv
package psm_pkg;
  // ==========================================
  // frame geometry and timing
  localparam int NUM_PAIRS     = 3;
  localparam int CORE_BYTES    = 144;
  localparam int POS_PER_BLOCK = 36;
  localparam int BLOCKS        = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CORE_FRAME_US = 500;
  localparam int BYTE_CYCLES   = CORE_FRAME_US * 1000 / CLK_PERIOD_NS / CORE_BYTES;
  localparam int RETRY_US      = 1000;
  localparam int RETRY_CYCLES  = RETRY_US * 1000 / CLK_PERIOD_NS;
  localparam logic [5:0] LAST_POS   = 6'h23;
  localparam logic [1:0] LAST_BLOCK = 2'h3;

  // ==========================================
  // byte values
  localparam logic [7:0] ALL_ONES   = 8'hff;
  localparam logic [7:0] MAINT_MASK = 8'h20;

  // ==========================================
  // register map
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PRIO_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] EOC_OFS    = 8'h0c;
  localparam int CTRL_PRIO_BIT = 2;
  localparam int CTRL_LOOP_BIT = 3;
  localparam int CTRL_INST_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
  localparam logic [31:0] PRIO_RESET = 32'hffff_ffff;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    MODE_THREE = 2'b00,
    MODE_TWO   = 2'b01,
    MODE_ALT   = 2'b10
  } psm_mode_t;

  typedef enum logic [1:0] {
    KIND_USER = 2'b00,
    KIND_TS0  = 2'b01,
    KIND_TS16 = 2'b10,
    KIND_FILL = 2'b11
  } psm_kind_t;

  typedef struct packed {
    logic [4:0] slot;
    logic [1:0] pair;
    psm_kind_t  kind;
  } psm_posmap_t;

  // core position to slot, owning pair and kind
  function automatic psm_posmap_t psm_map_pos(psm_mode_t mode, logic [5:0] pos);
    psm_posmap_t r;
    int p;
    p = int'(pos);
    r.kind = KIND_USER;
    r.slot = 5'h00;
    r.pair = 2'h0;
    if (mode == MODE_TWO) begin
      if (p <= 1) begin
        r.kind = KIND_TS0;
        r.pair = 2'(p);
      end else if (p <= 16) begin
        r.slot = 5'(p - 1);
        r.pair = 2'((p - 2) % 2);
      end else if (p <= 18) begin
        r.kind = KIND_TS16;
        r.slot = 5'h10;
        r.pair = 2'(p - 17);
      end else if (p <= 33) begin
        r.slot = 5'(p - 2);
        r.pair = 2'((p - 19) % 2);
      end else begin
        r.kind = KIND_FILL;
        r.pair = 2'(p - 34);
      end
    end else begin
      if (p <= 2) begin
        r.kind = KIND_TS0;
        r.pair = 2'(p);
      end else if (p <= 17) begin
        r.slot = 5'(p - 2);
        r.pair = 2'((p - 3) % 3);
      end else if (p <= 20) begin
        r.kind = KIND_TS16;
        r.slot = 5'h10;
        r.pair = 2'(p - 18);
      end else begin
        r.slot = 5'(p - 4);
        r.pair = 2'((p - 21) % 3);
      end
      if (mode == MODE_ALT) r.pair = 2'(p % 2);
    end
    return r;
  endfunction
endpackage

// ===== psm_link_if.sv
`timescale 1ns/10ps
interface psm_link_if;
  import psm_pkg::*;
  // ==========================================
  // core frame stream, central to remote
  logic [7:0] lineData;
  logic [1:0] linePair;
  logic       lineValid;
  logic       lineFrameStart;
  psm_mode_t  mode;
  logic       loopReq;
  logic [7:0] eocData [NUM_PAIRS];
  // ==========================================
  // pair status, remote to central
  logic [NUM_PAIRS-1:0] pairFail;
  logic [NUM_PAIRS-1:0] pairActivated;
  logic [NUM_PAIRS-1:0] pairIdOk;
  logic [NUM_PAIRS-1:0] syncWordLoss;

  modport central (
    output lineData, linePair, lineValid, lineFrameStart, mode, loopReq, eocData,
    input  pairFail, pairActivated, pairIdOk, syncWordLoss
  );
  modport remote (
    input  lineData, linePair, lineValid, lineFrameStart, mode, loopReq, eocData,
    output pairFail, pairActivated, pairIdOk, syncWordLoss
  );
endinterface

// ===== psm_remote_mapper.sv
`timescale 1ns/10ps
module psm_remote_mapper
  import psm_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_CYCLES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // transceiver flags
  input  wire logic [NUM_PAIRS-1:0] signalLossFlag,
  input  wire logic [NUM_PAIRS-1:0] frameAlignmentLoss,
  input  wire logic [NUM_PAIRS-1:0] syncWordLossIn,
  input  wire logic [NUM_PAIRS-1:0] activationDone,
  input  wire logic [NUM_PAIRS-1:0] pairIdOkIn,
  output logic      [NUM_PAIRS-1:0] restartReq,
  output logic      [NUM_PAIRS-1:0] loopActive,
  // application side
  output logic                      appOutValid,
  output logic      [4:0]           appOutSlot,
  output logic      [7:0]           appOutByte,
  output logic      [7:0]           eocRx,
  // link
  psm_link_if.remote                link
);
  initial begin
    if (RETRY_CYC < 2) $error("RETRY_CYC too small");
  end

  localparam int CW = $clog2(RETRY_CYC);

  logic [NUM_PAIRS-1:0] failFlag_reg;
  logic [NUM_PAIRS-1:0] failFlag_next;
  logic [CW-1:0]        retryCnt_reg [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] restart_reg;
  psm_mode_t            modeCopy_reg;
  logic [5:0]           pos_reg;
  logic [5:0]           posNow;
  psm_mode_t            modeNow;
  psm_posmap_t          m;

  // ==========================================
  // pair failure flags
  // loss sets, reactivation clears, set wins; sync word loss alone never fails
  assign failFlag_next = (signalLossFlag | frameAlignmentLoss)
                       | (failFlag_reg & ~activationDone);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      failFlag_reg <= '1;
    end else begin
      failFlag_reg <= failFlag_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.pairFail      <= '1;
      link.pairActivated <= '0;
      link.pairIdOk      <= '0;
      link.syncWordLoss  <= '0;
    end else begin
      link.pairFail      <= failFlag_reg;
      link.pairActivated <= activationDone;
      link.pairIdOk      <= pairIdOkIn;
      link.syncWordLoss  <= syncWordLossIn;
    end
  end

  // ==========================================
  // independent start-up retry per failed pair
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        retryCnt_reg[i] <= '0;
      end
      restart_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        if (failFlag_reg[i] && !activationDone[i]) begin
          restart_reg[i]  <= (retryCnt_reg[i] == '0);
          retryCnt_reg[i] <= (retryCnt_reg[i] == CW'(RETRY_CYC - 1)) ? '0
                           : CW'(retryCnt_reg[i] + 1'b1);
        end else begin
          retryCnt_reg[i] <= '0;
          restart_reg[i]  <= 1'b0;
        end
      end
    end
  end
  assign restartReq = restart_reg;

  // ==========================================
  // demapping of the core frame
  assign modeNow = link.lineFrameStart ? link.mode : modeCopy_reg;
  assign posNow  = link.lineFrameStart ? 6'h00
                 : (pos_reg == LAST_POS) ? 6'h00 : 6'(pos_reg + 1'b1);
  assign m       = psm_map_pos(modeNow, posNow);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeCopy_reg <= MODE_THREE;
      pos_reg      <= LAST_POS;
      appOutValid  <= 1'b0;
      appOutSlot   <= '0;
      appOutByte   <= ALL_ONES;
    end else begin
      appOutValid <= link.lineValid && (m.kind != KIND_FILL);
      if (link.lineValid) begin
        if (link.lineFrameStart) modeCopy_reg <= link.mode;
        pos_reg    <= posNow;
        appOutSlot <= m.slot;
        appOutByte <= (failFlag_reg[link.linePair] || m.kind == KIND_FILL)
                    ? ALL_ONES : link.lineData;
      end
    end
  end

  // ==========================================
  // eoc from the first working pair, loopback to every transceiver
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eocRx      <= '0;
      loopActive <= '0;
    end else begin
      loopActive <= {NUM_PAIRS{link.loopReq}};
      for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
        if (!failFlag_reg[i]) eocRx <= link.eocData[i];
      end
    end
  end
endmodule

// ===== psm_central_mapper.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module psm_central_mapper
  import psm_pkg::*;
#(
  parameter int BYTE_CYC = BYTE_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // application side
  output logic      [4:0]  appSlot,
  output logic             appTake,
  input  wire logic [7:0]  appByte,
  output logic      [31:0] appAisMask,
  // link
  psm_link_if.central      link
);
  initial begin
    if (BYTE_CYC < 2) $error("BYTE_CYC too small");
  end

  localparam int TW = $clog2(BYTE_CYC);

  logic [31:0]          ctrl_reg;
  logic [31:0]          prio_reg;
  logic [7:0]           eocTx_reg;
  logic [TW-1:0]        tickCnt_reg;
  logic [5:0]           pos_reg;
  logic [1:0]           block_reg;
  logic [NUM_PAIRS-1:0] live_reg;
  logic [NUM_PAIRS-1:0] installed_reg;
  psm_mode_t            modeAct_reg;
  logic                 prioAct_reg;
  logic                 operational_reg;
  logic                 tick;
  logic                 frameStart;
  logic                 frameEnd;
  logic                 degraded;
  logic                 carried;
  logic [NUM_PAIRS-1:0] installed;
  logic [NUM_PAIRS-1:0] ready;
  logic [7:0]           outByte;
  logic                 mapped;
  logic                 doWrite;
  psm_mode_t            ctrlMode;
  psm_posmap_t          m;

  assign installed = ctrl_reg[CTRL_INST_LSB +: NUM_PAIRS];
  assign ctrlMode  = psm_mode_t'(ctrl_reg[1:0]);

  // ==========================================
  // apb register file
  assign mapped  = (paddr == CTRL_OFS) || (paddr == PRIO_OFS)
                || (paddr == STATUS_OFS) || (paddr == EOC_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign doWrite = psel && penable && pwrite && mapped;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= CTRL_RESET;
      prio_reg  <= PRIO_RESET;
      eocTx_reg <= '0;
    end else if (doWrite) begin
      unique case (paddr)
        CTRL_OFS: ctrl_reg  <= pwdata;
        PRIO_OFS: prio_reg  <= pwdata;
        EOC_OFS:  eocTx_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        CTRL_OFS:   prdata <= ctrl_reg;
        PRIO_OFS:   prdata <= prio_reg;
        STATUS_OFS: prdata <= {12'h000, link.syncWordLoss, link.pairFail,
                               1'b0, live_reg, 1'b0, modeAct_reg, 1'b0,
                               operational_reg, degraded, prioAct_reg, 1'b0, 2'h0};
        EOC_OFS:    prdata <= {24'h000000, eocTx_reg};
        default:    prdata <= '0;
      endcase
    end
  end

  // ==========================================
  // byte timing: 36 positions, 4 blocks per core frame
  assign tick       = (tickCnt_reg == '0);
  assign frameStart = tick && pos_reg == '0 && block_reg == '0;
  assign frameEnd   = tick && pos_reg == LAST_POS && block_reg == LAST_BLOCK;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tickCnt_reg <= '0;
      pos_reg     <= '0;
      block_reg   <= '0;
    end else begin
      tickCnt_reg <= tick ? TW'(BYTE_CYC - 1) : TW'(tickCnt_reg - 1'b1);
      if (tick) begin
        pos_reg <= (pos_reg == LAST_POS) ? '0 : 6'(pos_reg + 1'b1);
        if (pos_reg == LAST_POS) begin
          block_reg <= (block_reg == LAST_BLOCK) ? '0 : 2'(block_reg + 1'b1);
        end
      end
    end
  end

  // ==========================================
  // live pairs and mapping state updated once per core frame, operational status every cycle
  assign ready = installed & link.pairActivated & link.pairIdOk & ~link.pairFail;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      live_reg      <= '0;
      installed_reg <= '0;
      modeAct_reg   <= MODE_THREE;
      prioAct_reg   <= 1'b0;
    end else if (frameEnd) begin
      // latched on the last byte so the next frame uses it from its first byte
      live_reg      <= ready;
      installed_reg <= installed;
      modeAct_reg   <= (ctrlMode == MODE_TWO || ctrlMode == MODE_ALT) ? ctrlMode
                     : MODE_THREE;
      prioAct_reg   <= ctrl_reg[CTRL_PRIO_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      operational_reg <= 1'b0;
    end else begin
      operational_reg <= (installed != '0) && (ready == installed);
    end
  end

  assign degraded = live_reg != installed_reg;

  // ==========================================
  // core frame fill
  assign m = psm_map_pos(modeAct_reg, pos_reg);

  always_comb begin
    carried = live_reg[m.pair];
    outByte = ALL_ONES;
    unique case (m.kind)
      KIND_USER: begin
        if (prioAct_reg && degraded && !prio_reg[m.slot]) carried = 1'b0;
        outByte = carried ? appByte : ALL_ONES;
      end
      KIND_TS0, KIND_TS16: begin
        outByte = carried ? (appByte | (degraded ? MAINT_MASK : 8'h00))
                : ALL_ONES;
      end
      KIND_FILL: begin
        carried = 1'b0;
        outByte = ALL_ONES;
      end
    endcase
  end

  assign appSlot = m.slot;
  assign appTake = tick && m.kind != KIND_FILL;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.lineData       <= ALL_ONES;
      link.linePair       <= '0;
      link.lineValid      <= 1'b0;
      link.lineFrameStart <= 1'b0;
      appAisMask          <= '1;
    end else begin
      link.lineValid      <= tick;
      link.lineFrameStart <= frameStart;
      if (tick) begin
        link.lineData <= outByte;
        link.linePair <= m.pair;
        if (m.kind == KIND_USER) appAisMask[m.slot] <= !carried;
      end
    end
  end

  // ==========================================
  // mode, loopback and operations channel towards the link
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.mode    <= MODE_THREE;
      link.loopReq <= 1'b0;
      for (int i = 0; i < NUM_PAIRS; i++) link.eocData[i] <= '0;
    end else begin
      if (frameStart) begin
        link.mode <= modeAct_reg;
      end
      link.loopReq <= ctrl_reg[CTRL_LOOP_BIT];
      for (int i = 0; i < NUM_PAIRS; i++) link.eocData[i] <= eocTx_reg;
    end
  end
endmodule

// ===== psm_link_asserts.sv
`timescale 1ns/10ps
module psm_link_asserts
  import psm_pkg::*;
#(
  parameter int BYTE_CYC = BYTE_CYCLES
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // central to remote
  input wire logic [7:0]           lineData,
  input wire logic [1:0]           linePair,
  input wire logic                 lineValid,
  input wire logic                 lineFrameStart,
  input wire psm_mode_t            mode,
  input wire logic                 loopReq,
  input wire logic [7:0]           eocData [NUM_PAIRS],
  // remote to central
  input wire logic [NUM_PAIRS-1:0] pairFail,
  input wire logic [NUM_PAIRS-1:0] pairActivated,
  input wire logic [NUM_PAIRS-1:0] pairIdOk,
  input wire logic [NUM_PAIRS-1:0] syncWordLoss
);
  // ==========================================
  // position tracking
  logic [15:0] gapCnt;
  logic [7:0]  byteCnt;
  logic        seenV;
  logic [7:0]  idx;
  int          pos;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gapCnt  <= 16'h0000;
      byteCnt <= 8'h00;
      seenV   <= 1'b0;
    end else if (lineValid) begin
      gapCnt  <= 16'h0000;
      byteCnt <= idx;
      seenV   <= 1'b1;
    end else begin
      gapCnt  <= gapCnt + 16'h0001;
    end
  end

  always_comb begin
    idx = lineFrameStart ? 8'h00 : byteCnt + 8'h01;
    pos = int'(idx) % POS_PER_BLOCK;
  end

  // expected pair of a core position
  function automatic logic [1:0] pairOf(psm_mode_t m, int p);
    if (m == MODE_ALT) return 2'(p % 2);
    if (m == MODE_TWO) begin
      if (p <= 1) return 2'(p);
      if (p <= 16) return 2'((p - 2) % 2);
      if (p <= 18) return 2'(p - 17);
      if (p <= 33) return 2'((p - 19) % 2);
      return 2'(p - 34);
    end
    if (p <= 2) return 2'(p);
    if (p <= 17) return 2'((p - 3) % 3);
    if (p <= 20) return 2'(p - 18);
    return 2'((p - 21) % 3);
  endfunction

  // ==========================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_start;
    lineValid && lineFrameStart;
  endsequence

  a_start_valid: assert property (lineFrameStart |-> lineValid)
    else $error("frame start without a byte");
  a_frame_len: assert property (lineValid && lineFrameStart && seenV |-> byteCnt == 8'h8f)
    else $error("frame not 144 bytes");
  a_start_single: assert property (s_start |=> (!lineFrameStart) [*8])
    else $error("frame start repeated");
  a_byte_gap: assert property (lineValid && seenV |-> gapCnt == 16'(BYTE_CYC - 1))
    else $error("byte spacing wrong");
  a_mode_edge: assert property ($changed(mode) |-> lineFrameStart || $past(lineFrameStart))
    else $error("mode changed inside a frame");
  a_three_layout: assert property (lineValid && mode == MODE_THREE |-> linePair == pairOf(MODE_THREE, pos))
    else $error("three pair layout wrong");
  a_two_layout: assert property (lineValid && mode == MODE_TWO |-> linePair == pairOf(MODE_TWO, pos))
    else $error("two pair layout wrong");
  a_alt_layout: assert property (lineValid && mode == MODE_ALT |-> linePair == pairOf(MODE_ALT, pos))
    else $error("alternative layout wrong");
  a_fill_ones: assert property (lineValid && mode == MODE_TWO && pos >= 34 |-> lineData == ALL_ONES)
    else $error("fill position not all ones");
  a_eoc_same: assert property (eocData[0] == eocData[1] && eocData[1] == eocData[2])
    else $error("operations channel differs per pair");
endmodule

// ===== partial_operation_slot_mapper_tb.sv
`timescale 1ns/10ps
module partial_operation_slot_mapper_tb
  import psm_pkg::*;
;
  localparam int FRAME_CYC = 576;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, appTake;
  logic        appOutValid, chkOn, degExp, prioOn, restartSeen;
  logic [7:0]  paddr, appByte, appOutByte, eocRx;
  logic [31:0] pwdata, prdata, appAisMask, prioExp;
  logic [4:0]  appSlot, appOutSlot;
  logic [2:0]  signalLossFlag, frameAlignmentLoss, syncWordLoss, activationDone, pairIdOk;
  logic [2:0]  restartReq, loopActive, liveExp;
  logic [1:0]  pairQ;
  psm_mode_t   modeExp;
  int          fail_count, comparisons, cycles;

  psm_link_if link ();
  psm_central_mapper #(.BYTE_CYC(4)) psm_central_mapper_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .appSlot(appSlot), .appTake(appTake), .appByte(appByte), .appAisMask(appAisMask),
    .link(link));
  psm_remote_mapper #(.RETRY_CYC(8)) psm_remote_mapper_inst (
    .core_clk(core_clk), .rst(rst), .signalLossFlag(signalLossFlag),
    .frameAlignmentLoss(frameAlignmentLoss), .syncWordLossIn(syncWordLoss),
    .activationDone(activationDone), .pairIdOkIn(pairIdOk), .restartReq(restartReq),
    .loopActive(loopActive), .appOutValid(appOutValid), .appOutSlot(appOutSlot),
    .appOutByte(appOutByte), .eocRx(eocRx), .link(link));
  psm_link_asserts #(.BYTE_CYC(4)) psm_link_asserts_inst (
    .core_clk(core_clk), .rst(rst), .lineData(link.lineData), .linePair(link.linePair),
    .lineValid(link.lineValid), .lineFrameStart(link.lineFrameStart), .mode(link.mode),
    .loopReq(link.loopReq), .eocData(link.eocData), .pairFail(link.pairFail),
    .pairActivated(link.pairActivated), .pairIdOk(link.pairIdOk),
    .syncWordLoss(link.syncWordLoss));

  always #5 core_clk = ~core_clk;

  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q & m, exp);
  endtask

  task automatic frames(input int n);
    repeat (n * FRAME_CYC) @(posedge core_clk);
  endtask

  task automatic phase(input int n, input logic [2:0] live, input logic deg);
    liveExp = live;
    degExp = deg;
    frames(2);
    chkOn <= 1'b1;
    frames(1);
    chkOn <= 1'b0;
    $display("test %0d done", n);
  endtask

  function automatic logic [1:0] slotPair(psm_mode_t m, logic [4:0] s);
    if (m == MODE_TWO) return {1'b0, ~s[0]};
    if (m == MODE_ALT) return {1'b0, s[0]};
    return 2'((s < 5'h10 ? int'(s) - 1 : int'(s) - 17) % 3);
  endfunction

  function automatic logic [7:0] userExp(logic [4:0] s, logic [1:0] p);
    return (!liveExp[p] || (prioOn && degExp && !prioExp[s])) ? 8'hff
         : (8'h5a ^ {3'h0, s});
  endfunction

  // ==========================================
  // monitor of the remote application side
  always @(posedge core_clk) begin
    // slot-dependent application byte, so misplaced slots show up
    appByte <= 8'h5a ^ {3'h0, appSlot};
    if (link.lineValid) pairQ <= link.linePair;
    if (restartReq[1]) restartSeen <= 1'b1;
    if (chkOn && appOutValid) begin
      if (appOutSlot == 5'h00 || appOutSlot == 5'h10) begin
        check(32'(appOutByte), 32'(liveExp[pairQ] ? ((8'h5a ^ {3'h0, appOutSlot})
              | (degExp ? MAINT_MASK : 8'h00)) : 8'hff));
      end else begin
        check(32'(appOutByte), 32'(userExp(appOutSlot, pairQ)));
        check(32'(pairQ), 32'(slotPair(modeExp, appOutSlot)));
      end
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    core_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    appByte = 8'h5a; signalLossFlag = 0; frameAlignmentLoss = 0; syncWordLoss = 0;
    activationDone = 0; pairIdOk = 0; chkOn = 0; degExp = 0; prioOn = 0;
    prioExp = '1; liveExp = 0; modeExp = MODE_THREE; restartSeen = 0; pairQ = 0;
    fail_count = 0; comparisons = 0; cycles = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(CTRL_OFS, 32'hffff_ffff, CTRL_RESET);
    rdchk(PRIO_OFS, 32'hffff_ffff, PRIO_RESET);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check(q, 32'h0);
    check(32'(e), 32'h1);
    wr(EOC_OFS, 32'ha5);
    activationDone <= 3'h7;
    pairIdOk <= 3'h7;
    phase(1, 3'h7, 1'b0);
    rdchk(STATUS_OFS, 32'h0000_1c30, 32'h0000_1c20);
    check(appAisMask & 32'hfffe_fffe, 32'h0);
    check(32'(eocRx), 32'ha5);
    wr(CTRL_OFS, 32'h78);
    repeat (3) @(posedge core_clk);
    check(32'(loopActive), 32'h7);
    wr(CTRL_OFS, 32'h70);
    pairIdOk <= 3'h3;
    frames(2);
    rdchk(STATUS_OFS, 32'h20, 32'h0);
    pairIdOk <= 3'h7;
    signalLossFlag <= 3'h2;
    restartSeen <= 1'b0;
    activationDone <= 3'h5;
    phase(2, 3'h5, 1'b1);
    rdchk(STATUS_OFS, 32'h0001_c030, 32'h0000_8010);
    check(appAisMask & 32'hfffe_fffe, 32'h4924_4924);
    check(32'(restartSeen), 32'h1);
    check(32'(eocRx), 32'ha5);
    signalLossFlag <= 3'h0;
    activationDone <= 3'h7;
    syncWordLoss <= 3'h1;
    phase(3, 3'h7, 1'b0);
    rdchk(STATUS_OFS, 32'h000e_0020, 32'h0002_0020);
    syncWordLoss <= 3'h0;
    wr(CTRL_OFS, 32'h31);
    modeExp = MODE_TWO;
    phase(4, 3'h3, 1'b0);
    rdchk(STATUS_OFS, 32'h180, 32'h080);
    wr(CTRL_OFS, 32'h32);
    modeExp = MODE_ALT;
    frameAlignmentLoss <= 3'h1;
    phase(5, 3'h2, 1'b1);
    frameAlignmentLoss <= 3'h0;
    wr(PRIO_OFS, 32'h0000_ffff);
    wr(CTRL_OFS, 32'h74);
    modeExp = MODE_THREE;
    prioExp = 32'h0000_ffff;
    prioOn = 1'b1;
    signalLossFlag <= 3'h4;
    phase(6, 3'h3, 1'b1);
    rdchk(STATUS_OFS, 32'h8, 32'h8);
    close_out();
  end
endmodule
